// >>> hdl/load_monitor_defines.svh
// Purpose: offsets, field positions, reset values and timing counts of the load monitor
// Assumes: 25 MHz control clock, APB byte addresses on 8 bits
// Notes:   torque values are whole percent of nominal motor torque
`ifndef LOAD_MONITOR_DEFINES_SVH
`define LOAD_MONITOR_DEFINES_SVH

// register byte offsets
`define LM_CTRL_OFS        8'h00
`define LM_NORMAL_OFS      8'h04
`define LM_OVER_MARG_OFS   8'h08
`define LM_UNDER_MARG_OFS  8'h0c
`define LM_OVER_DEL_OFS    8'h10
`define LM_UNDER_DEL_OFS   8'h14
`define LM_START_DEL_OFS   8'h18
`define LM_ABS_MARG_OFS    8'h1c
`define LM_MIN_SPEED_OFS   8'h20
`define LM_INV_STEP_OFS    8'h24
`define LM_STATUS_OFS      8'h28
`define LM_IRQ_STAT_OFS    8'h2c
`define LM_IRQ_EN_OFS      8'h30
`define LM_IRQ_CLR_OFS     8'h34
`define LM_CURVE_BASE_OFS  8'h40

// ctrl field positions
`define LM_CTRL_ALARM_LSB  0
`define LM_CTRL_TRIP_LSB   2
`define LM_CTRL_RAMP_BIT   4
`define LM_CTRL_REF_LSB    5

// reset values
`define LM_CTRL_RST        7'h00
`define LM_NORMAL_RST      10'h064
`define LM_CURVE_RST       10'h064
`define LM_MARGIN_RST      9'h00f
`define LM_ABS_MARG_RST    5'h03
`define LM_MIN_SPEED_RST   15'h0000
`define LM_INV_STEP_RST    16'h0000

// limits
`define LM_MARGIN_MAX      9'h190
`define LM_START_MAX_S     12'he10
`define LM_DELAY_MAX_MS    17'h15f90
`define LM_REF_TYPE_MAX    2'h2

// timing
`define LM_CLK_HZ          25000000
`define LM_TICK_US         1000
`define LM_TICK_CYCLES     ((`LM_CLK_HZ / 1000000) * `LM_TICK_US)
`define LM_PERSIST_DEF_MS  17'h00064
`define LM_START_DEF_S     12'h002
`define LM_MS_PER_S        22'h0003e8
`define LM_PCT_SCALE       21'h000064

`endif

// >>> hdl/lm_pkg.sv
// Purpose: types shared by the load monitor files
// Assumes: nothing beyond the defines header
// Notes:   field widths follow the register layout
package lm_pkg;
   typedef enum logic [1:0] {
      ST_IDLE      = 2'b00,
      ST_WAIT_RAMP = 2'b01,
      ST_DELAY     = 2'b11,
      ST_ARMED     = 2'b10
   } start_state_e;

   typedef enum logic [1:0] {
      REF_FIXED = 2'h0,
      REF_CURVE = 2'h1,
      REF_REL   = 2'h2
   } ref_type_e;

   typedef struct packed {
      logic [1:0] ref_type;
      logic       ramp_alarm;
      logic [1:0] trip_sel;
      logic [1:0] alarm_sel;
   } ctrl_s;

   typedef struct packed {
      logic        run;
      logic        accel;
      logic        decel;
      logic [9:0]  load;
      logic [14:0] speed;
   } drive_s;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_s;
endpackage

// >>> hdl/persist_timer.sv
// Purpose: persistence timer, raises active after cond held longer than limit ticks
// Assumes: tick is a one-cycle pulse on the same clock
// Notes:   any drop of cond restarts the count and clears active
`timescale 1ns/1ps
module persist_timer #(
   parameter int CW = 17
) (
   input  logic          clk,
   input  logic          rst,
   input  logic          tick,
   input  logic          cond,
   input  logic [CW-1:0] limit,
   output logic          active
);
   if (CW < 2) begin : g_bad_cw
      $error("persist_timer: CW too small");
   end

   logic [CW-1:0] cnt_q;

   always_ff @(posedge clk) begin
      if (rst || !cond) begin
         cnt_q  <= '0;
         active <= 1'b0;
      end else if (tick && !active) begin
         if (cnt_q >= limit) begin
            active <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

   AST_PT_CLEAR: assert property (@(posedge clk) disable iff (rst)
      !cond |=> !active) else $error("alarm held after band re-entered");
   AST_PT_NOT_EARLY: assert property (@(posedge clk) disable iff (rst)
      $rose(active) |-> $past(cnt_q) >= $past(limit) && $past(cond) && $past(tick))
      else $error("alarm raised before persistence delay");
endmodule

// >>> hdl/load_monitor_alarm.sv
// Purpose: load monitor with over/underload alarms, trip request and APB registers
// Assumes: DRIVE and TRIP_RESET come from logic on MCLK; APB on MCLK
// Notes:   one wait state on every APB access; alarms lag the load by two cycles
//
// What this block does
// - alarm select: 0 none, 1 underload, 2 overload, 3 both.
// - trip select uses the same codes, default off, picks alarms that trip.
// - ramp alarm 0 suppresses alarms during ramps, 1 keeps them; default 0.
// - with ramp alarms on, start delay counts from run; no alarm before expiry.
// - with ramp alarms off, start delay counts from end of acceleration.
// - start delay 0 to 3600 s, default 2 s.
// - reference type: 0 fixed, 1 load curve, 2 relative curve; default fixed.
// - fixed mode uses one normal load over the whole speed range.
// - curve mode interpolates 9 points over 8 equal speed steps.
// - relative mode margin is a fraction of curve load, floored by absolute margin.
// - overload margin is a band above reference, 0 to 400 %, default 15 %.
// - relative mode margins are percent of curve torque at present speed.
// - overload alarm after load above level longer than delay, 0 to 90 s.
// - underload alarm after load below level longer than delay, default 0.1 s.
// - underload margin is a band below reference, 0 to 400 %, default 15 %.
`timescale 1ns/1ps
`include "load_monitor_defines.svh"
module load_monitor_alarm #(
   parameter int TICK_CYCLES = `LM_TICK_CYCLES
) (
   input  logic             MCLK,
   input  logic             RST,
   input  lm_pkg::apb_req_s APB,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  lm_pkg::drive_s   DRIVE,
   input  logic             TRIP_RESET,
   output logic             OVER_ALARM,
   output logic             UNDER_ALARM,
   output logic             TRIP_REQ,
   output logic             IRQ
);
   import lm_pkg::*;

   if (TICK_CYCLES < 2 || TICK_CYCLES > 32767) begin : g_bad_tick
      $error("load_monitor_alarm: TICK_CYCLES out of range");
   end

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   ctrl_s                ctrl_q;
   logic [9:0]           normal_q;
   logic [8:0]           over_marg_q;
   logic [8:0]           under_marg_q;
   logic [16:0]          over_del_q;
   logic [16:0]          under_del_q;
   logic [11:0]          start_s_q;
   logic [4:0]           abs_marg_q;
   logic [14:0]          min_speed_q;
   logic [15:0]          inv_step_q;
   logic [9:0]           curve_q [0:8];
   logic [2:0]           irq_stat_q;
   logic [2:0]           irq_en_q;
   start_state_e         st_q;
   start_state_e         st_d;
   logic [21:0]          sd_cnt_q;
   logic [14:0]          pre_q;
   logic                 tick_q;
   logic [9:0]           ref_q;
   logic                 above_q;
   logic                 below_q;
   logic                 over_prev_q;
   logic                 under_prev_q;
   logic                 trip_prev_q;

   // apb decode
   wire        acc      = APB.psel && APB.penable && PREADY;
   wire        wr       = acc && APB.pwrite;
   wire [7:0]  a        = APB.paddr;
   wire [31:0] wd       = APB.pwdata;
   wire        aligned  = (a[1:0] == 2'b00);
   wire        curve_hit = aligned && (a[7:6] == 2'b01) && (a[5:2] <= 4'h8);
   wire [3:0]  curve_idx = a[5:2];
   wire        hit_ctrl  = aligned && (a == `LM_CTRL_OFS);
   wire        hit_norm  = aligned && (a == `LM_NORMAL_OFS);
   wire        hit_om    = aligned && (a == `LM_OVER_MARG_OFS);
   wire        hit_um    = aligned && (a == `LM_UNDER_MARG_OFS);
   wire        hit_od    = aligned && (a == `LM_OVER_DEL_OFS);
   wire        hit_ud    = aligned && (a == `LM_UNDER_DEL_OFS);
   wire        hit_sd    = aligned && (a == `LM_START_DEL_OFS);
   wire        hit_abs   = aligned && (a == `LM_ABS_MARG_OFS);
   wire        hit_minsp = aligned && (a == `LM_MIN_SPEED_OFS);
   wire        hit_inv   = aligned && (a == `LM_INV_STEP_OFS);
   wire        hit_stat  = aligned && (a == `LM_STATUS_OFS);
   wire        hit_is    = aligned && (a == `LM_IRQ_STAT_OFS);
   wire        hit_ie    = aligned && (a == `LM_IRQ_EN_OFS);
   wire        hit_ic    = aligned && (a == `LM_IRQ_CLR_OFS);
   wire        mapped    = hit_ctrl | hit_norm | hit_om | hit_um | hit_od | hit_ud | hit_sd
                         | hit_abs | hit_minsp | hit_inv | hit_stat | hit_is | hit_ie
                         | hit_ic | curve_hit;

   // out-of-range margin, delay and start writes saturate at the documented maximum; a bad reference type falls back to fixed
   wire [8:0]  marg_w   = (wd[8:0] > `LM_MARGIN_MAX || wd[31:9] != '0) ? `LM_MARGIN_MAX
                                                                         : wd[8:0];
   wire [16:0] del_w    = (wd[16:0] > `LM_DELAY_MAX_MS || wd[31:17] != '0) ? `LM_DELAY_MAX_MS
                                                                             : wd[16:0];
   wire [11:0] start_w  = (wd[11:0] > `LM_START_MAX_S || wd[31:12] != '0) ? `LM_START_MAX_S
                                                                          : wd[11:0];
   wire [1:0]  ref_wr   = wd[`LM_CTRL_REF_LSB +: 2];
   wire [1:0]  reft_w   = (ref_wr > `LM_REF_TYPE_MAX) ? REF_FIXED : ref_wr;
   wire ctrl_s ctrl_w   = '{ref_type: reft_w, ramp_alarm: wd[`LM_CTRL_RAMP_BIT],
                            trip_sel: wd[`LM_CTRL_TRIP_LSB +: 2],
                            alarm_sel: wd[`LM_CTRL_ALARM_LSB +: 2]};

   wire [31:0] status_w = {17'h00000, ref_q, st_q, TRIP_REQ, UNDER_ALARM, OVER_ALARM};
   wire [31:0] rdata    = hit_ctrl  ? {25'h0, ctrl_q} :
                          hit_norm  ? {22'h0, normal_q} :
                          hit_om    ? {23'h0, over_marg_q} :
                          hit_um    ? {23'h0, under_marg_q} :
                          hit_od    ? {15'h0, over_del_q} :
                          hit_ud    ? {15'h0, under_del_q} :
                          hit_sd    ? {20'h0, start_s_q} :
                          hit_abs   ? {27'h0, abs_marg_q} :
                          hit_minsp ? {17'h0, min_speed_q} :
                          hit_inv   ? {16'h0, inv_step_q} :
                          hit_stat  ? status_w :
                          hit_is    ? {29'h0, irq_stat_q} :
                          hit_ie    ? {29'h0, irq_en_q} :
                          curve_hit ? {22'h0, curve_q[curve_idx]} : 32'h0000_0000;

   always_ff @(posedge MCLK) begin
      if (RST) begin
         PREADY  <= 1'b0;
         PRDATA  <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= APB.psel && APB.penable && !PREADY;
         PRDATA  <= (APB.psel && !APB.pwrite) ? rdata : 32'h0000_0000;
         PSLVERR <= APB.psel && APB.penable && !PREADY && !mapped;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         ctrl_q       <= `LM_CTRL_RST;
         normal_q     <= `LM_NORMAL_RST;
         over_marg_q  <= `LM_MARGIN_RST;
         under_marg_q <= `LM_MARGIN_RST;
         over_del_q   <= `LM_PERSIST_DEF_MS;
         under_del_q  <= `LM_PERSIST_DEF_MS;
         start_s_q    <= `LM_START_DEF_S;
         abs_marg_q   <= `LM_ABS_MARG_RST;
         min_speed_q  <= `LM_MIN_SPEED_RST;
         inv_step_q   <= `LM_INV_STEP_RST;
         irq_en_q     <= 3'h0;
      end else if (wr) begin
         if (hit_ctrl)  ctrl_q       <= ctrl_w;
         if (hit_norm)  normal_q     <= wd[9:0];
         if (hit_om)    over_marg_q  <= marg_w;
         if (hit_um)    under_marg_q <= marg_w;
         if (hit_od)    over_del_q   <= del_w;
         if (hit_ud)    under_del_q  <= del_w;
         if (hit_sd)    start_s_q    <= start_w;
         if (hit_abs)   abs_marg_q   <= wd[4:0];
         if (hit_minsp) min_speed_q  <= wd[14:0];
         if (hit_inv)   inv_step_q   <= wd[15:0];
         if (hit_ie)    irq_en_q     <= wd[2:0];
      end
   end

   for (genvar i = 0; i < 9; i++) begin : g_curve
      always_ff @(posedge MCLK) begin
         if (RST) begin
            curve_q[i] <= `LM_CURVE_RST;
         end else if (wr && curve_hit && curve_idx == 4'(i)) begin
            curve_q[i] <= wd[9:0];
         end
      end
   end

   // millisecond tick
   always_ff @(posedge MCLK) begin
      if (RST || pre_q == 15'(TICK_CYCLES - 1)) begin
         pre_q <= 15'h0000;
      end else begin
         pre_q <= pre_q + 15'h0001;
      end
      tick_q <= !RST && (pre_q == 15'(TICK_CYCLES - 1));
   end

   // curve interpolation; inv_step holds 65536 / speed step
   wire [14:0] sp_off   = (DRIVE.speed > min_speed_q) ? DRIVE.speed - min_speed_q : 15'h0000;
   wire [30:0] pos      = sp_off * inv_step_q;
   wire        past_end = (pos[30:16] >= 15'h0008);
   wire [3:0]  seg      = past_end ? 4'h8 : {1'b0, pos[18:16]};
   wire [7:0]  frac     = past_end ? 8'h00 : pos[15:8];
   wire [9:0]  lo       = curve_q[seg];
   wire [9:0]  hi       = past_end ? curve_q[8] : curve_q[seg + 4'h1];
   wire signed [10:0] diff  = $signed({1'b0, hi}) - $signed({1'b0, lo});
   wire signed [19:0] prodi = diff * $signed({1'b0, frac});
   wire signed [11:0] rsum  = $signed({2'b00, lo}) + prodi[19:8];
   wire [9:0]  ref_curve = rsum[9:0];
   wire [9:0]  ref_w     = (ctrl_q.ref_type == REF_FIXED) ? normal_q : ref_curve;

   // comparisons in hundredths of percent, avoids a divider
   wire [20:0] ref100   = 21'(ref_q) * `LM_PCT_SCALE;
   wire [20:0] load100  = 21'(DRIVE.load) * `LM_PCT_SCALE;
   wire [20:0] abs100   = 21'(abs_marg_q) * `LM_PCT_SCALE;
   wire [20:0] om_rel   = 21'(ref_q) * 21'(over_marg_q);
   wire [20:0] um_rel   = 21'(ref_q) * 21'(under_marg_q);
   wire        rel      = (ctrl_q.ref_type == REF_REL);
   wire [20:0] om_w     = rel ? ((om_rel < abs100) ? abs100 : om_rel)
                              : 21'(over_marg_q) * `LM_PCT_SCALE;
   wire [20:0] um_w     = rel ? ((um_rel < abs100) ? abs100 : um_rel)
                              : 21'(under_marg_q) * `LM_PCT_SCALE;

   always_ff @(posedge MCLK) begin
      if (RST) begin
         ref_q   <= `LM_NORMAL_RST;
         above_q <= 1'b0;
         below_q <= 1'b0;
      end else begin
         ref_q   <= ref_w;
         above_q <= load100 > ref100 + om_w;
         below_q <= load100 + um_w < ref100;
      end
   end

   // start delay sequencer
   wire [21:0] sd_target = 22'(start_s_q) * `LM_MS_PER_S;
   wire        sd_done   = (sd_cnt_q >= sd_target);

   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: begin
            if (DRIVE.run) st_d = ctrl_q.ramp_alarm ? ST_DELAY : ST_WAIT_RAMP;
         end
         ST_WAIT_RAMP: begin
            if (!DRIVE.accel) st_d = ST_DELAY;
         end
         ST_DELAY: begin
            if (sd_done) st_d = ST_ARMED;
         end
         ST_ARMED: begin
            st_d = ST_ARMED;
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
      if (!DRIVE.run) st_d = ST_IDLE;
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         st_q     <= ST_IDLE;
         sd_cnt_q <= 22'h000000;
      end else begin
         st_q     <= st_d;
         sd_cnt_q <= (st_q != ST_DELAY) ? 22'h000000 : sd_cnt_q + 22'(tick_q && !sd_done);
      end
   end

   // gating: armed, ramp window, selector
   wire ramping    = DRIVE.accel || DRIVE.decel;
   wire window_ok  = (st_q == ST_ARMED) && (ctrl_q.ramp_alarm || !ramping);
   wire over_cond  = window_ok && ctrl_q.alarm_sel[1] && above_q;
   wire under_cond = window_ok && ctrl_q.alarm_sel[0] && below_q;

   persist_timer #(.CW(17)) u_over (
      .clk    (MCLK),
      .rst    (RST),
      .tick   (tick_q),
      .cond   (over_cond),
      .limit  (over_del_q),
      .active (OVER_ALARM)
   );

   persist_timer #(.CW(17)) u_under (
      .clk    (MCLK),
      .rst    (RST),
      .tick   (tick_q),
      .cond   (under_cond),
      .limit  (under_del_q),
      .active (UNDER_ALARM)
   );

   wire trip_set = (OVER_ALARM && ctrl_q.trip_sel[1]) || (UNDER_ALARM && ctrl_q.trip_sel[0]);
   // set beats a reset pulse in the same cycle
   wire [2:0] ev = {TRIP_REQ && !trip_prev_q, UNDER_ALARM && !under_prev_q,
                    OVER_ALARM && !over_prev_q};

   always_ff @(posedge MCLK) begin
      if (RST) begin
         TRIP_REQ     <= 1'b0;
         over_prev_q  <= 1'b0;
         under_prev_q <= 1'b0;
         trip_prev_q  <= 1'b0;
         irq_stat_q   <= 3'h0;
         IRQ          <= 1'b0;
      end else begin
         TRIP_REQ     <= trip_set || (TRIP_REQ && !TRIP_RESET);
         over_prev_q  <= OVER_ALARM;
         under_prev_q <= UNDER_ALARM;
         trip_prev_q  <= TRIP_REQ;
         irq_stat_q   <= ev | (irq_stat_q & ~((wr && hit_ic) ? wd[2:0] : 3'h0));
         IRQ          <= |(irq_stat_q & irq_en_q);
      end
   end

   AST_SEL_OFF: assert property ((ctrl_q.alarm_sel == 2'h0) |=> !OVER_ALARM && !UNDER_ALARM)
      else $error("alarm active with selector off");
   AST_TRIP_SET: assert property (OVER_ALARM && ctrl_q.trip_sel[1] |=> TRIP_REQ)
      else $error("selected overload alarm did not trip");
   AST_TRIP_NOSEL: assert property ($rose(TRIP_REQ) |-> $past(trip_set))
      else $error("trip without selected alarm");
   AST_RAMP_SUPPRESS: assert property (!ctrl_q.ramp_alarm && ramping
      |=> !OVER_ALARM && !UNDER_ALARM) else $error("alarm during ramp while inhibited");
   AST_NOT_ARMED: assert property ((st_q != ST_ARMED) |=> !OVER_ALARM && !UNDER_ALARM)
      else $error("alarm before start delay expired");
   AST_WAIT_ACCEL: assert property ((st_q == ST_WAIT_RAMP) && DRIVE.run && DRIVE.accel
      |=> st_q == ST_WAIT_RAMP) else $error("start delay began during acceleration");
   AST_ARM_TIME: assert property ($changed(st_q) && st_q == ST_ARMED
      |-> $past(sd_cnt_q) >= $past(sd_target)) else $error("armed before start delay");
   AST_REF_TYPE: assert property (ctrl_q.ref_type != 2'h3)
      else $error("illegal reference type stored");
   AST_FIXED_REF: assert property ((ctrl_q.ref_type == REF_FIXED) && $stable(ctrl_q)
      |=> ref_q == $past(normal_q)) else $error("fixed reference not used");
   AST_REL_FLOOR: assert property (rel && (load100 <= ref100 + abs100) |=> !above_q)
      else $error("relative margin below absolute minimum");
   AST_MARGIN_MAX: assert property (over_marg_q <= `LM_MARGIN_MAX
      && under_marg_q <= `LM_MARGIN_MAX) else $error("margin above 400 percent");
   AST_TRIP_HOLD: assert property (TRIP_REQ && !TRIP_RESET |=> TRIP_REQ)
      else $error("trip request dropped without reset");

   COV_OVER: cover property ($rose(OVER_ALARM));
   COV_UNDER: cover property ($rose(UNDER_ALARM));
   COV_TRIP: cover property ($rose(TRIP_REQ));
   COV_ARMED: cover property ((st_q == ST_DELAY) ##1 (st_q == ST_ARMED));
endmodule

// >>> tb/drive_core_model.sv
// Purpose: drive control core model feeding run, ramp, load and speed to the load monitor
// Assumes: same clock as the monitor, synchronous active-high reset
// Notes:   accel stands for RAMP cycles after each run rise, decel follows decel_cmd
`timescale 1ns/1ps
module drive_core_model #(
   parameter int RAMP = 40
) (
   input  logic           clk,
   input  logic           rst,
   input  logic           run_cmd,
   input  logic           decel_cmd,
   input  logic [9:0]     load_cmd,
   output lm_pkg::drive_s drive
);
   import lm_pkg::*;
   int ramp_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         drive  <= '0;
         ramp_q <= 0;
      end else begin
         drive.run   <= run_cmd;
         drive.load  <= load_cmd;
         drive.decel <= decel_cmd && run_cmd;
         // ramp restarts on every run rise, so a stop mid-ramp is modelled too
         if (run_cmd && !drive.run) begin
            ramp_q      <= RAMP - 1;
            drive.accel <= 1'b1;
         end else if (ramp_q > 0 && run_cmd) begin
            ramp_q      <= ramp_q - 1;
            drive.speed <= drive.speed + 15'h0001;
         end else begin
            ramp_q      <= 0;
            drive.accel <= 1'b0;
         end
         if (!run_cmd) begin
            drive.speed <= '0;
         end
      end
   end
endmodule

// >>> tb/load_monitor_alarm_tb.sv
// Purpose: self-checking bench for the load monitor alarm block
// Assumes: TICK_CYCLES shortened to 4, so one ms tick is 4 clocks
// Notes:   timing windows come from delay ticks, see lo_c and hi_c
`timescale 1ns/1ps
`include "load_monitor_defines.svh"
module load_monitor_alarm_tb;
   import lm_pkg::*;
   localparam int          TK = 4;
   localparam logic [7:0]  RA [6] = '{`LM_CTRL_OFS, `LM_NORMAL_OFS, `LM_OVER_MARG_OFS,
                                      `LM_UNDER_MARG_OFS, `LM_UNDER_DEL_OFS, `LM_START_DEL_OFS};
   localparam logic [31:0] RE [6] = '{0, 100, 15, 15, 100, 2};
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   apb_req_s    apb = '0;
   drive_s      drive;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, over_alarm, under_alarm, trip_req, irq, er;
   logic        run_cmd = 1'b0;
   logic        decel_cmd = 1'b0;
   logic [9:0]  load_cmd = 10'd100;
   logic        trip_reset = 1'b0;
   int          fails = 0;
   int          num_checks = 0;
   int          cyc = 0;
   int          seed = 35423;

   always #20 mclk = ~mclk;

   drive_core_model #(.RAMP(40)) core (.clk(mclk), .rst(rst), .run_cmd(run_cmd),
      .decel_cmd(decel_cmd), .load_cmd(load_cmd), .drive(drive));
   load_monitor_alarm #(.TICK_CYCLES(TK)) uut (.MCLK(mclk), .RST(rst), .APB(apb),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .DRIVE(drive),
      .TRIP_RESET(trip_reset), .OVER_ALARM(over_alarm), .UNDER_ALARM(under_alarm),
      .TRIP_REQ(trip_req), .IRQ(irq));

   function automatic int lo_c(input int ticks);
      return ticks * TK;
   endfunction
   function automatic int hi_c(input int ticks);
      return (ticks + 1) * TK + 6;
   endfunction

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      if (fails == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         close_out();
      end
   end

   // request held from setup until the edge that samples pready high
   task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge mclk);
      apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
      @(posedge mclk);
      apb.penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      apb <= '0;
      check("pready", (n < 20), 1);
   endtask

   task automatic expect_rise(input int which, input int lo, input int hi);
      int         n;
      logic [2:0] v;
      n = 0;
      v = '0;
      while (v[which] !== 1'b1 && n < hi) begin
         @(posedge mclk);
         v = {trip_req, under_alarm, over_alarm};
         n++;
      end
      check("rise window", {v[which], (n > lo)}, 2'b11);
   endtask

   task automatic start_run(input logic [31:0] ctrl, input logic [9:0] ld);
      run_cmd <= 1'b0;
      apb_xfer(1'b1, `LM_CTRL_OFS, ctrl);
      load_cmd <= ld;
      run_cmd <= 1'b1;
   endtask

   initial begin
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         apb_xfer(1'b0, RA[i], 0);
         check("reset value", rd, RE[i]);
      end
      apb_xfer(1'b0, 8'h88, 0);
      check("unmapped err", er, 1);
      apb_xfer(1'b1, `LM_START_DEL_OFS, 0);
      apb_xfer(1'b1, `LM_OVER_DEL_OFS, 2);
      apb_xfer(1'b1, `LM_UNDER_DEL_OFS, 2);
      apb_xfer(1'b1, `LM_IRQ_EN_OFS, 32'h7);
      // both alarms, overload trips, alarms kept during ramps, fixed reference
      start_run(32'h1b, 10'd115);
      repeat (30) @(posedge mclk);
      check("inside band", {trip_req, under_alarm, over_alarm}, 0);
      load_cmd <= 10'd116;
      expect_rise(0, lo_c(2), hi_c(2));
      expect_rise(2, 0, 3);
      repeat (3) @(posedge mclk);
      check("irq raised", irq, 1);
      apb_xfer(1'b0, `LM_IRQ_STAT_OFS, 0);
      check("irq status", rd[2:0], 3'b101);
      apb_xfer(1'b1, `LM_IRQ_EN_OFS, 0);
      repeat (3) @(posedge mclk);
      check("irq masked", irq, 0);
      load_cmd <= 10'd100;
      apb_xfer(1'b1, `LM_IRQ_EN_OFS, 32'h7);
      apb_xfer(1'b1, `LM_IRQ_CLR_OFS, 32'h7);
      repeat (3) @(posedge mclk);
      check("cleared", {irq, trip_req, over_alarm}, 3'b010);
      @(posedge mclk);
      trip_reset <= 1'b1;
      @(posedge mclk);
      trip_reset <= 1'b0;
      load_cmd <= 10'd84;
      expect_rise(1, lo_c(2), hi_c(2));
      repeat (4) @(posedge mclk);
      check("no under trip", trip_req, 0);
      // overload bursts too short to persist, broken by one in-band cycle
      for (int k = 0; k < 30; k++) begin
         @(posedge mclk);
         load_cmd <= 10'd116 + 10'($unsigned($random(seed)) % 200);
         repeat (1 + $unsigned($random(seed)) % 7) @(posedge mclk);
         load_cmd <= 10'd85 + 10'($unsigned($random(seed)) % 31);
         check("burst", over_alarm, 0);
      end
      start_run(32'h0b, 10'd200);
      expect_rise(0, 40, 40 + hi_c(2));
      // a decel ramp while armed must drop the alarm when ramp alarms are off
      decel_cmd <= 1'b1;
      repeat (3) @(posedge mclk);
      check("decel inhibit", over_alarm, 0);
      decel_cmd <= 1'b0;
      start_run(32'h3b, 10'd66);
      for (int i = 0; i < 9; i++) begin
         apb_xfer(1'b1, `LM_CURVE_BASE_OFS + 8'(4 * i), 50);
      end
      expect_rise(0, 0, 30 + hi_c(2));
      apb_xfer(1'b1, `LM_OVER_MARG_OFS, 500);
      apb_xfer(1'b0, `LM_OVER_MARG_OFS, 0);
      check("margin clamp", rd, 400);
      apb_xfer(1'b1, `LM_OVER_MARG_OFS, 2);
      start_run(32'h5b, 10'd53);
      repeat (30) @(posedge mclk);
      check("abs floor", over_alarm, 0);
      apb_xfer(1'b1, `LM_OVER_MARG_OFS, 15);
      start_run(32'h5b, 10'd58);
      expect_rise(0, 0, hi_c(2));
      start_run(32'h10, 10'd200);
      repeat (30) @(posedge mclk);
      check("select off", {under_alarm, over_alarm}, 0);
      start_run(32'h12, 10'd50);
      repeat (30) @(posedge mclk);
      check("select over only", under_alarm, 0);
      apb_xfer(1'b1, `LM_START_DEL_OFS, 1);
      start_run(32'h1b, 10'd200);
      expect_rise(0, lo_c(1000), lo_c(1000) + hi_c(2));
      close_out();
   end
endmodule
